//--- common/uiedp_pkg.sv
// shared constants, answer codes and carriers of the endpoint data path
package uiedp_pkg;
  // register byte addresses
  localparam logic [7:0] A_IN_DATA = 8'h00;
  localparam logic [7:0] A_OUT_DATA = 8'h08;
  localparam logic [7:0] A_IN_CTRL = 8'h10;
  localparam logic [7:0] A_OUT_STAT = 8'h11;
  localparam logic [7:0] A_EVT = 8'h12;
  localparam logic [7:0] A_DEV = 8'h13;
  // field positions
  localparam int unsigned CTRL_TOGGLE = 7;
  localparam int unsigned CTRL_ARM = 4;
  localparam int unsigned EVT_TX = 0;
  localparam int unsigned EVT_RX = 1;
  localparam int unsigned DEV_CFG = 7;
  // packet limit and reset values
  localparam logic [3:0] MAX_PKT = 4'h8;
  localparam logic [3:0] CNT_RST = 4'h0;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // standard request codes
  localparam logic [7:0] REQ_CLR_FEAT = 8'h01;
  localparam logic [7:0] REQ_SET_ADDR = 8'h05;
  localparam logic [7:0] REQ_GET_DESC = 8'h06;
  localparam logic [7:0] REQ_SET_CONF = 8'h09;
  localparam logic [7:0] FEAT_EP_HALT = 8'h00;
  localparam logic [7:0] CONF_MAX = 8'h01;
  // descriptor types
  localparam logic [7:0] DT_DEVICE = 8'h01;
  localparam logic [7:0] DT_CONFIG = 8'h02;
  localparam logic [7:0] DT_STRING = 8'h03;
  // device descriptor fields
  localparam logic [7:0] DD_LEN = 8'h12;
  localparam logic [7:0] DD_BCD_LO = 8'h10;
  localparam logic [7:0] DD_BCD_HI = 8'h01;
  localparam logic [7:0] DD_CLASS = 8'h00;
  localparam logic [7:0] DD_EP0_MAX = 8'h08;
  localparam logic [7:0] DD_IDX_MFR = 8'h01;
  localparam logic [7:0] DD_IDX_PROD = 8'h02;
  localparam logic [7:0] DD_IDX_SER = 8'h00;
  localparam logic [7:0] DD_NUM_CONF = 8'h01;
  // answer codes toward the host
  typedef enum logic [2:0] {
    UIEDP_PID_NONE = 3'h0,
    UIEDP_PID_NAK = 3'h1,
    UIEDP_PID_ACK = 3'h2,
    UIEDP_PID_STALL = 3'h3,
    UIEDP_PID_DATA0 = 3'h4,
    UIEDP_PID_DATA1 = 3'h5
  } uiedp_pid_e;
  // received out packet
  typedef struct packed {
    logic [3:0] len;
    logic [7:0][7:0] data;
  } uiedp_out_pkt_s;
  // answer to an in token
  typedef struct packed {
    uiedp_pid_e pid;
    logic [3:0] len;
    logic [7:0][7:0] data;
  } uiedp_in_pkt_s;
  // decoded standard setup request
  typedef struct packed {
    logic [7:0] code;
    logic [7:0] value_lo;
    logic [7:0] value_hi;
  } uiedp_req_s;
endpackage : uiedp_pkg

//--- logic/uiedp_core.sv
// interrupt endpoint data path: in/out endpoints, requests, descriptor
//
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module uiedp_core #(
  parameter logic [15:0] VENDOR_ID = 16'h1234, // arbitrary value
  parameter logic [15:0] PRODUCT_ID = 16'h5678, // arbitrary value
  parameter logic [15:0] DEV_REL = 16'h0100
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  // register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // endpoint one, in direction
  input wire logic in_token_in,
  input wire logic in_ack_in,
  output uiedp_pkg::uiedp_in_pkt_s in_pkt_out,
  // endpoint two, out direction
  input wire logic out_valid_in,
  input wire uiedp_pkg::uiedp_out_pkt_s out_pkt_in,
  output uiedp_pkg::uiedp_pid_e out_hs_out,
  // standard requests
  input wire logic req_valid_in,
  input wire uiedp_pkg::uiedp_req_s req_in,
  output uiedp_pkg::uiedp_pid_e req_ans_out,
  // device descriptor read
  input wire logic [4:0] desc_idx_in,
  output logic [7:0] desc_byte_out,
  // service request to local logic
  output logic svc_req_out
);

  // endpoint data bytes
  logic [7:0][7:0] in_endpoint_data_bytes;
  logic [7:0][7:0] next_in_endpoint_data_bytes;
  logic [7:0][7:0] out_endpoint_data_bytes;
  logic [7:0][7:0] next_out_endpoint_data_bytes;
  // in endpoint control fields
  logic [3:0] tx_byte_count;
  logic [3:0] next_tx_byte_count;
  logic tx_data_toggle;
  logic next_tx_data_toggle;
  logic tx_arm_enable;
  logic next_tx_arm_enable;
  logic tx_sent; // data answered, waiting for ack
  logic next_tx_sent;
  // out endpoint status and event flags
  logic [3:0] rx_byte_count;
  logic [3:0] next_rx_byte_count;
  logic tx_complete_flag;
  logic next_tx_complete_flag;
  logic rx_received_flag;
  logic next_rx_received_flag;
  // device state
  logic configured;
  logic next_configured;
  logic [6:0] dev_addr;
  logic [6:0] next_dev_addr;
  // registered outputs
  logic [7:0] next_reg_rdata;
  uiedp_pkg::uiedp_in_pkt_s next_in_pkt;
  uiedp_pkg::uiedp_pid_e next_out_hs;
  uiedp_pkg::uiedp_pid_e next_req_ans;
  logic [7:0] next_desc_byte;

  // device descriptor bytes, multi-byte fields low byte first
  function automatic logic [7:0] desc_rom(input logic [4:0] idx);
    logic [7:0] b;
    b = uiedp_pkg::BYTE_ZERO;
    unique case (idx)
      5'h00: b = uiedp_pkg::DD_LEN;
      5'h01: b = uiedp_pkg::DT_DEVICE;
      5'h02: b = uiedp_pkg::DD_BCD_LO;
      5'h03: b = uiedp_pkg::DD_BCD_HI;
      5'h04: b = uiedp_pkg::DD_CLASS;
      5'h05: b = uiedp_pkg::DD_CLASS;
      5'h06: b = uiedp_pkg::DD_CLASS;
      5'h07: b = uiedp_pkg::DD_EP0_MAX;
      5'h08: b = VENDOR_ID[7:0];
      5'h09: b = VENDOR_ID[15:8];
      5'h0A: b = PRODUCT_ID[7:0];
      5'h0B: b = PRODUCT_ID[15:8];
      5'h0C: b = DEV_REL[7:0];
      5'h0D: b = DEV_REL[15:8];
      5'h0E: b = uiedp_pkg::DD_IDX_MFR;
      5'h0F: b = uiedp_pkg::DD_IDX_PROD;
      5'h10: b = uiedp_pkg::DD_IDX_SER;
      5'h11: b = uiedp_pkg::DD_NUM_CONF;
      default: b = uiedp_pkg::BYTE_ZERO; // beyond the descriptor
    endcase
    return b;
  endfunction : desc_rom

  // next state of the whole data path
  always_comb begin
    next_in_endpoint_data_bytes = in_endpoint_data_bytes;
    next_out_endpoint_data_bytes = out_endpoint_data_bytes;
    next_tx_byte_count = tx_byte_count;
    next_tx_data_toggle = tx_data_toggle;
    next_tx_arm_enable = tx_arm_enable;
    next_tx_sent = tx_sent;
    next_rx_byte_count = rx_byte_count;
    next_tx_complete_flag = tx_complete_flag;
    next_rx_received_flag = rx_received_flag;
    next_configured = configured;
    next_dev_addr = dev_addr;
    next_reg_rdata = uiedp_pkg::BYTE_ZERO;
    next_in_pkt = '0;
    next_out_hs = uiedp_pkg::UIEDP_PID_NONE;
    next_req_ans = uiedp_pkg::UIEDP_PID_NONE;
    next_desc_byte = desc_rom(desc_idx_in);

    // software writes; hardware sets below win over clears here
    if (reg_wr_in) begin
      if (reg_addr_in[7:3] == uiedp_pkg::A_IN_DATA[7:3]) begin
        // payload bytes of the in endpoint
        next_in_endpoint_data_bytes[reg_addr_in[2:0]] = reg_wdata_in;
      end else if (reg_addr_in == uiedp_pkg::A_IN_CTRL) begin
        // count, toggle and arm in one write; arm is the last step
        next_tx_byte_count = reg_wdata_in[3:0];
        next_tx_data_toggle = reg_wdata_in[uiedp_pkg::CTRL_TOGGLE];
        next_tx_arm_enable = reg_wdata_in[uiedp_pkg::CTRL_ARM];
      end else if (reg_addr_in == uiedp_pkg::A_EVT) begin
        // write one to clear
        if (reg_wdata_in[uiedp_pkg::EVT_TX]) begin
          next_tx_complete_flag = 1'b0;
        end
        if (reg_wdata_in[uiedp_pkg::EVT_RX]) begin
          next_rx_received_flag = 1'b0;
        end
      end
    end

    // in token on endpoint one
    if (in_token_in) begin
      next_tx_sent = 1'b0;
      if (configured && tx_arm_enable) begin
        // armed: data packet, empty when the count is zero
        next_in_pkt.pid = tx_data_toggle ? uiedp_pkg::UIEDP_PID_DATA1
                                         : uiedp_pkg::UIEDP_PID_DATA0;
        next_in_pkt.len = (tx_byte_count > uiedp_pkg::MAX_PKT)
                          ? uiedp_pkg::MAX_PKT : tx_byte_count;
        next_in_pkt.data = in_endpoint_data_bytes;
        next_tx_sent = 1'b1;
      end else begin
        // disarmed or unconfigured: nak only
        next_in_pkt.pid = uiedp_pkg::UIEDP_PID_NAK;
      end
    end else if (in_ack_in && tx_sent) begin
      // host took the packet: disarm and flag completion
      next_tx_sent = 1'b0;
      next_tx_arm_enable = 1'b0;
      next_tx_complete_flag = 1'b1;
    end

    // out packet on endpoint two
    if (out_valid_in) begin
      if (!configured || rx_received_flag) begin
        // previous data not taken yet, or not configured
        next_out_hs = uiedp_pkg::UIEDP_PID_NAK;
      end else if (out_pkt_in.len <= uiedp_pkg::MAX_PKT) begin
        // store, count, flag and acknowledge
        next_out_endpoint_data_bytes = out_pkt_in.data;
        next_rx_byte_count = out_pkt_in.len;
        next_rx_received_flag = 1'b1;
        next_out_hs = uiedp_pkg::UIEDP_PID_ACK;
      end
    end

    // standard requests
    if (req_valid_in) begin
      next_req_ans = uiedp_pkg::UIEDP_PID_STALL;
      unique case (req_in.code)
        uiedp_pkg::REQ_SET_ADDR: begin
          // any address value
          next_dev_addr = req_in.value_lo[6:0];
          next_req_ans = uiedp_pkg::UIEDP_PID_ACK;
        end
        uiedp_pkg::REQ_GET_DESC: begin
          // device, configuration and string only
          if (req_in.value_hi == uiedp_pkg::DT_DEVICE ||
              req_in.value_hi == uiedp_pkg::DT_CONFIG ||
              req_in.value_hi == uiedp_pkg::DT_STRING) begin
            next_req_ans = uiedp_pkg::UIEDP_PID_ACK;
          end
        end
        uiedp_pkg::REQ_SET_CONF: begin
          // configuration value 0 or 1 only
          if (req_in.value_lo <= uiedp_pkg::CONF_MAX) begin
            next_configured = (req_in.value_lo != uiedp_pkg::BYTE_ZERO);
            next_req_ans = uiedp_pkg::UIEDP_PID_ACK;
          end
        end
        uiedp_pkg::REQ_CLR_FEAT: begin
          // endpoint halt is the only feature
          if (req_in.value_lo == uiedp_pkg::FEAT_EP_HALT) begin
            next_req_ans = uiedp_pkg::UIEDP_PID_ACK;
          end
        end
        default: begin
          // unsupported request stalls
          next_req_ans = uiedp_pkg::UIEDP_PID_STALL;
        end
      endcase
    end

    // register reads, data in the next cycle only
    if (reg_rd_in) begin
      if (reg_addr_in[7:3] == uiedp_pkg::A_IN_DATA[7:3]) begin
        next_reg_rdata = in_endpoint_data_bytes[reg_addr_in[2:0]];
      end else if (reg_addr_in[7:3] == uiedp_pkg::A_OUT_DATA[7:3]) begin
        next_reg_rdata = out_endpoint_data_bytes[reg_addr_in[2:0]];
      end else if (reg_addr_in == uiedp_pkg::A_IN_CTRL) begin
        next_reg_rdata = {tx_data_toggle, 2'b00, tx_arm_enable,
                          tx_byte_count};
      end else if (reg_addr_in == uiedp_pkg::A_OUT_STAT) begin
        next_reg_rdata = {4'h0, rx_byte_count};
      end else if (reg_addr_in == uiedp_pkg::A_EVT) begin
        next_reg_rdata = {6'h00, rx_received_flag, tx_complete_flag};
      end else if (reg_addr_in == uiedp_pkg::A_DEV) begin
        next_reg_rdata = {configured, dev_addr};
      end
    end
  end

  // registers of the data path
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      in_endpoint_data_bytes <= '0;
      out_endpoint_data_bytes <= '0;
      tx_byte_count <= uiedp_pkg::CNT_RST;
      tx_data_toggle <= 1'b0;
      tx_arm_enable <= 1'b0;
      tx_sent <= 1'b0;
      rx_byte_count <= uiedp_pkg::CNT_RST;
      tx_complete_flag <= 1'b0;
      rx_received_flag <= 1'b0;
      configured <= 1'b0;
      dev_addr <= 7'h00;
      reg_rdata_out <= uiedp_pkg::BYTE_ZERO;
      in_pkt_out <= '0;
      out_hs_out <= uiedp_pkg::UIEDP_PID_NONE;
      req_ans_out <= uiedp_pkg::UIEDP_PID_NONE;
      desc_byte_out <= uiedp_pkg::BYTE_ZERO;
      svc_req_out <= 1'b0;
    end else begin
      in_endpoint_data_bytes <= next_in_endpoint_data_bytes;
      out_endpoint_data_bytes <= next_out_endpoint_data_bytes;
      tx_byte_count <= next_tx_byte_count;
      tx_data_toggle <= next_tx_data_toggle;
      tx_arm_enable <= next_tx_arm_enable;
      tx_sent <= next_tx_sent;
      rx_byte_count <= next_rx_byte_count;
      tx_complete_flag <= next_tx_complete_flag;
      rx_received_flag <= next_rx_received_flag;
      configured <= next_configured;
      dev_addr <= next_dev_addr;
      reg_rdata_out <= next_reg_rdata;
      in_pkt_out <= next_in_pkt;
      out_hs_out <= next_out_hs;
      req_ans_out <= next_req_ans;
      desc_byte_out <= next_desc_byte;
      // service request follows the flags
      svc_req_out <= next_tx_complete_flag | next_rx_received_flag;
    end
  end

  // checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);

  // armed token on a configured device
  sequence s_armed_token;
    in_token_in && configured && tx_arm_enable;
  endsequence
  // data packet sent, then acknowledged
  sequence s_sent_acked;
    in_token_in && configured && tx_arm_enable ##1
      !in_token_in && in_ack_in;
  endsequence

  chk_nak_disarmed: assert property (
    in_token_in && !(configured && tx_arm_enable) |=>
      in_pkt_out.pid == uiedp_pkg::UIEDP_PID_NAK)
    else $error("disarmed endpoint did not nak");
  chk_toggle_pid: assert property (
    s_armed_token |=> in_pkt_out.pid ==
      ($past(tx_data_toggle) ? uiedp_pkg::UIEDP_PID_DATA1
                             : uiedp_pkg::UIEDP_PID_DATA0))
    else $error("data pid does not follow toggle");
  chk_zero_len: assert property (
    (s_armed_token and (tx_byte_count == uiedp_pkg::CNT_RST)) |=>
      in_pkt_out.len == uiedp_pkg::CNT_RST &&
      in_pkt_out.pid != uiedp_pkg::UIEDP_PID_NAK)
    else $error("armed empty endpoint sent no empty packet");
  chk_ack_disarm: assert property (
    s_sent_acked |=> !tx_arm_enable && tx_complete_flag ##1 svc_req_out)
    else $error("ack did not disarm and flag");
  chk_out_store: assert property (
    out_valid_in && configured && !rx_received_flag &&
      out_pkt_in.len <= uiedp_pkg::MAX_PKT |=>
      out_hs_out == uiedp_pkg::UIEDP_PID_ACK && rx_received_flag &&
      rx_byte_count == $past(out_pkt_in.len))
    else $error("valid out packet not stored");
  chk_out_hold: assert property (
    out_valid_in && rx_received_flag |=>
      out_hs_out == uiedp_pkg::UIEDP_PID_NAK &&
      $stable(out_endpoint_data_bytes))
    else $error("out packet overran untaken data");
  chk_cfg_gate: assert property (
    !configured && (in_token_in || out_valid_in) |=>
      in_pkt_out.pid != uiedp_pkg::UIEDP_PID_DATA0 &&
      in_pkt_out.pid != uiedp_pkg::UIEDP_PID_DATA1 &&
      out_hs_out != uiedp_pkg::UIEDP_PID_ACK)
    else $error("endpoint active before configuration");
  chk_conf_value: assert property (
    req_valid_in && req_in.code == uiedp_pkg::REQ_SET_CONF &&
      req_in.value_lo > uiedp_pkg::CONF_MAX |=>
      req_ans_out == uiedp_pkg::UIEDP_PID_STALL && $stable(configured))
    else $error("bad configuration value accepted");
  chk_desc_release: assert property (
    desc_idx_in == 5'h02 ##1 desc_idx_in == 5'h03 |=>
      $past(desc_byte_out) == uiedp_pkg::DD_BCD_LO &&
      desc_byte_out == uiedp_pkg::DD_BCD_HI)
    else $error("release number wrong");
  chk_rx_count_read: assert property (
    reg_rd_in && reg_addr_in == uiedp_pkg::A_OUT_STAT && !out_valid_in |=>
      reg_rdata_out == {4'h0, rx_byte_count})
    else $error("rx count read wrong");

endmodule : uiedp_core

//--- tb/uiedp_host_model.sv
// host model: polls endpoint one, sends out packets and setup requests
`timescale 1ns/1ps
module uiedp_host_model #(
  parameter int POLL_GAP = 4 // scaled poll interval in clock cycles
) (
  // clock
  input wire logic core_clk_in,
  // in endpoint
  output logic in_token_out,
  output logic in_ack_out,
  input wire uiedp_pkg::uiedp_in_pkt_s in_pkt_in,
  // out endpoint
  output logic out_valid_out,
  output uiedp_pkg::uiedp_out_pkt_s out_pkt_out,
  input wire uiedp_pkg::uiedp_pid_e out_hs_in,
  // standard requests
  output logic req_valid_out,
  output uiedp_pkg::uiedp_req_s req_out,
  input wire uiedp_pkg::uiedp_pid_e req_ans_in
);
  // idle host at time zero
  initial begin
    in_token_out = 1'b0;
    in_ack_out = 1'b0;
    out_valid_out = 1'b0;
    out_pkt_out = '0;
    req_valid_out = 1'b0;
    req_out = '0;
  end
  // one token after the poll gap, answer taken in the cycle after it
  task automatic poll_in(output uiedp_pkg::uiedp_in_pkt_s ans);
    repeat (POLL_GAP) @(posedge core_clk_in);
    in_token_out <= 1'b1;
    @(posedge core_clk_in);
    in_token_out <= 1'b0;
    @(negedge core_clk_in);
    ans = in_pkt_in;
  endtask : poll_in
  // acknowledge of the data packet just received
  task automatic ack();
    @(posedge core_clk_in);
    in_ack_out <= 1'b1;
    @(posedge core_clk_in);
    in_ack_out <= 1'b0;
  endtask : ack
  // out packet; released lines show the inverse, not the old value
  task automatic send_out(input uiedp_pkg::uiedp_out_pkt_s p,
                          output uiedp_pkg::uiedp_pid_e hs);
    @(posedge core_clk_in);
    out_valid_out <= 1'b1;
    out_pkt_out <= p;
    @(posedge core_clk_in);
    out_valid_out <= 1'b0;
    out_pkt_out <= ~p;
    @(negedge core_clk_in);
    hs = out_hs_in;
  endtask : send_out
  // setup request, answer taken in the following cycle
  task automatic send_req(input uiedp_pkg::uiedp_req_s r,
                          output uiedp_pkg::uiedp_pid_e ans);
    @(posedge core_clk_in);
    req_valid_out <= 1'b1;
    req_out <= r;
    @(posedge core_clk_in);
    req_valid_out <= 1'b0;
    req_out <= ~r;
    @(negedge core_clk_in);
    ans = req_ans_in;
  endtask : send_req
endmodule : uiedp_host_model

//--- tb/uiedp_core_tb.sv
// self-checking bench of the interrupt endpoint data path
`timescale 1ns/1ps
module uiedp_core_tb;
  localparam logic [15:0] VID = 16'h4a21; // arbitrary value
  localparam logic [15:0] PID = 16'h0b37; // arbitrary value
  localparam int LIMIT = 20000; // cycle ceiling of the run
  // request table: code, value low, value high, expected answer
  localparam logic [31:0] RQ [11] = '{
    32'h057f_0002, 32'h0600_0102, 32'h0600_0202, 32'h0600_0302,
    32'h0600_0403, 32'h0902_0003, 32'h0900_0002, 32'h0901_0002,
    32'h0100_0002, 32'h0101_0003, 32'h0300_0003};
  // descriptor table: index, expected byte
  localparam logic [15:0] DD [14] = '{
    16'h0101, 16'h0210, 16'h0301, 16'h0400, 16'h0500, 16'h0600,
    {8'h08, VID[7:0]}, {8'h09, VID[15:8]}, {8'h0a, PID[7:0]},
    {8'h0b, PID[15:8]}, 16'h0e01, 16'h0f02, 16'h1000, 16'h1200};
  // design ports
  logic core_clk_in, sys_rst_in, reg_wr_in, reg_rd_in;
  logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, desc_byte_out;
  logic in_token_in, in_ack_in, out_valid_in, req_valid_in, svc_req_out;
  logic [4:0] desc_idx_in;
  uiedp_pkg::uiedp_in_pkt_s in_pkt_out;
  uiedp_pkg::uiedp_out_pkt_s out_pkt_in;
  uiedp_pkg::uiedp_pid_e out_hs_out, req_ans_out;
  uiedp_pkg::uiedp_req_s req_in;
  // score keeping
  int fail_count = 0;
  int checks = 0;
  int cycles = 0;

  uiedp_core #(.VENDOR_ID(VID), .PRODUCT_ID(PID)) u_dut (
    .core_clk_in, .sys_rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
    .reg_rd_in, .reg_rdata_out, .in_token_in, .in_ack_in, .in_pkt_out,
    .out_valid_in, .out_pkt_in, .out_hs_out, .req_valid_in, .req_in,
    .req_ans_out, .desc_idx_in, .desc_byte_out, .svc_req_out);

  uiedp_host_model u_host (
    .core_clk_in, .in_token_out(in_token_in), .in_ack_out(in_ack_in),
    .in_pkt_in(in_pkt_out), .out_valid_out(out_valid_in),
    .out_pkt_out(out_pkt_in), .out_hs_in(out_hs_out),
    .req_valid_out(req_valid_in), .req_out(req_in),
    .req_ans_in(req_ans_out));

  // 125 MHz clock
  initial begin
    core_clk_in = 1'b0;
    forever #4 core_clk_in = ~core_clk_in;
  end
  // verdict and end of run
  task automatic print_verdict();
    if (fail_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict
  // hang guard
  always @(posedge core_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      fail_count++;
      print_verdict();
    end
  end
  // compare of a byte, count or answer code
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  // register write, one strobe cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge core_clk_in);
    reg_wr_in <= 1'b0;
  endtask : wr
  // register read, data checked in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge core_clk_in);
    reg_rd_in <= 1'b0;
    @(negedge core_clk_in);
    cmp(reg_rdata_out, exp);
  endtask : rd_chk

  // main sequence
  initial begin
    uiedp_pkg::uiedp_in_pkt_s ip;
    uiedp_pkg::uiedp_out_pkt_s op;
    uiedp_pkg::uiedp_pid_e hs;
    int k;
    sys_rst_in = 1'b1;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    reg_addr_in = 8'h00;
    reg_wdata_in = 8'h00;
    desc_idx_in = 5'h00;
    op = '0;
    repeat (8) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    // not yet configured: both endpoints refuse
    rd_chk(8'h10, 8'h00);
    wr(8'h10, 8'h90);
    u_host.poll_in(ip);
    cmp(ip.pid, uiedp_pkg::UIEDP_PID_NAK);
    op.len = 4'h2;
    u_host.send_out(op, hs);
    cmp(hs, uiedp_pkg::UIEDP_PID_NAK);
    // every supported and refused request, ends configured
    for (k = 0; k < 11; k++) begin
      u_host.send_req(RQ[k][31:8], hs);
      cmp(hs, RQ[k][7:0]);
    end
    rd_chk(8'h13, 8'hff);
    // device descriptor bytes
    for (k = 0; k < 14; k++) begin
      @(posedge core_clk_in);
      desc_idx_in <= DD[k][12:8];
      @(posedge core_clk_in);
      @(negedge core_clk_in);
      cmp(desc_byte_out, DD[k][7:0]);
    end
    // load, size, toggle and arm, then poll
    for (k = 0; k < 8; k++) wr(8'(k), 8'ha0 + 8'(k));
    wr(8'h10, 8'h93);
    u_host.poll_in(ip);
    cmp(ip.pid, uiedp_pkg::UIEDP_PID_DATA1);
    cmp(ip.len, 8'h03);
    for (k = 0; k < 3; k++) cmp(ip.data[k], 8'ha0 + 8'(k));
    u_host.ack();
    @(negedge core_clk_in);
    cmp(svc_req_out, 8'h01);
    rd_chk(8'h12, 8'h01);
    rd_chk(8'h10, 8'h83);
    wr(8'h12, 8'h01);
    @(negedge core_clk_in);
    cmp(svc_req_out, 8'h00);
    // disarmed: nak, and a stray ack raises nothing
    u_host.poll_in(ip);
    cmp(ip.pid, uiedp_pkg::UIEDP_PID_NAK);
    u_host.ack();
    rd_chk(8'h12, 8'h00);
    // armed with nothing to send: empty packet, other toggle
    wr(8'h10, 8'h10);
    u_host.poll_in(ip);
    cmp(ip.pid, uiedp_pkg::UIEDP_PID_DATA0);
    cmp(ip.len, 8'h00);
    u_host.ack();
    wr(8'h12, 8'h01);
    // full out packet stored and counted
    for (k = 0; k < 8; k++) op.data[k] = 8'h30 + 8'(k);
    op.len = 4'h8;
    u_host.send_out(op, hs);
    cmp(hs, uiedp_pkg::UIEDP_PID_ACK);
    rd_chk(8'h11, 8'h08);
    for (k = 0; k < 8; k++) rd_chk(8'h08 + 8'(k), 8'h30 + 8'(k));
    wr(8'h09, 8'h55);
    rd_chk(8'h09, 8'h31);
    rd_chk(8'h20, 8'h00);
    // untaken data: next packet refused, bytes kept
    op.len = 4'h2;
    op.data[0] = 8'hee;
    u_host.send_out(op, hs);
    cmp(hs, uiedp_pkg::UIEDP_PID_NAK);
    rd_chk(8'h08, 8'h30);
    rd_chk(8'h12, 8'h02);
    wr(8'h12, 8'h02);
    // empty packet then an oversize one
    op.len = 4'h0;
    u_host.send_out(op, hs);
    cmp(hs, uiedp_pkg::UIEDP_PID_ACK);
    rd_chk(8'h11, 8'h00);
    wr(8'h12, 8'h02);
    op.len = 4'h9;
    u_host.send_out(op, hs);
    cmp(hs, uiedp_pkg::UIEDP_PID_NONE);
    rd_chk(8'h12, 8'h00);
    // back to unconfigured: armed endpoint answers nak
    u_host.send_req(24'h09_0000, hs);
    cmp(hs, uiedp_pkg::UIEDP_PID_ACK);
    wr(8'h10, 8'h91);
    u_host.poll_in(ip);
    cmp(ip.pid, uiedp_pkg::UIEDP_PID_NAK);
    print_verdict();
  end
endmodule : uiedp_core_tb
